// ### core/sdw_device.sv
// Converter write port: serial receiver, mode and code registers, decoder
// What this block does
// - frame starts on select falling edge only
// - sample data each shift clock fall
// - execute command on 24th falling edge
// - host keeps select high 33 ns
// - host may park select low idle
// - host shift clock at most 30 MHz
// - word holds mode bits then code
// - mode from bits 17 and 16
// - mode codes normal, tristate, 100k, 1k
// - power-down disconnects output, stops core
// - power-down word still loads its code
// - host waits recovery after leaving power-down
// - early select rise discards frame
// - preset code at power-up until write
// - all-ones word triggers software reset
// - select rise cannot abort software reset
// - code is straight binary
// - top four bits to 15 thermometer segments
// - host sends most significant bit first
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`default_nettype none
module sdw_device
   import sdw_pkg::*;
#(
   parameter bit PRESET_MID = 1'b1
) (
   input  wire logic                   core_clk,
   input  wire logic                   srst,
   sdw_link_if.device                  link,
   output var  logic [CODE_BITS-1:0]   dacCode,
   output var  sdw_mode_t              opMode,
   output var  logic                   outputConnected,
   output var  logic                   coreEnabled,
   output var  logic                   pull100k,
   output var  logic                   pull1k,
   output var  logic [SEG_COUNT-1:0]   segmentSwitches,
   output var  logic [LADDER_BITS-1:0] ladderSwitches,
   output var  logic                   softResetPulse
);
   // ------------------------------------------------------------
   // Pin sampling
   // ------------------------------------------------------------
   logic [2:0] pinSync;
   logic       selN;
   logic       sclk;
   logic       sdin;

   // One shared two-stage path keeps select, clock and data aligned
   sdw_sync2 #(.WIDTH(3)) u_sdw_sync2 (
      .core_clk (core_clk),
      .srst     (srst),
      .async    ({link.frameSelN, link.shiftClk, link.serialData}),
      .synced   (pinSync)
   );
   assign {selN, sclk, sdin} = pinSync;

   // ------------------------------------------------------------
   // Code decoding
   // ------------------------------------------------------------
   // Thermometer steps move one switch per code step, keeping glitches small
   function automatic logic [SEG_COUNT-1:0] thermo(input logic [SEG_BITS-1:0] v);
      logic [SEG_COUNT-1:0] t;
      t = '0;
      for (int i = 0; i < SEG_COUNT; i++) begin
         t[i] = (32'(v) > i);
      end
      return t;
   endfunction

   function automatic logic [SEG_COUNT-1:0] thermoSeg(input logic [CODE_BITS-1:0] c);
      return thermo(c[CODE_BITS-1 -: SEG_BITS]);
   endfunction

   // ------------------------------------------------------------
   // Receiver state
   // ------------------------------------------------------------
   logic                 selN_q, selN_d;
   logic                 sclk_q, sclk_d;
   logic                 armed_q, armed_d;
   logic [4:0]           cnt_q, cnt_d;
   logic [FRAME_BITS-1:0] shift_q, shift_d;
   logic [CODE_BITS-1:0] code_q, code_d;
   sdw_mode_t            mode_q, mode_d;
   logic                 swr_q, swr_d;
   logic                 conn_q, conn_d;
   logic                 en_q, en_d;
   logic                 p100_q, p100_d;
   logic                 p1k_q, p1k_d;
   logic [SEG_COUNT-1:0] seg_q, seg_d;
   logic [LADDER_BITS-1:0] lad_q, lad_d;

   logic                 selFall;
   logic                 selRise;
   logic                 clkFall;
   logic [FRAME_BITS-1:0] word;
   logic [CODE_BITS-1:0] presetCode;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   // Serial receiver and stored registers; edges come from the synced pins
   always_comb begin
      selFall    = selN_q & ~selN;
      selRise    = ~selN_q & selN;
      clkFall    = sclk_q & ~sclk;
      presetCode = PRESET_MID ? CODE_MID : CODE_ZERO;
      word       = {shift_q[FRAME_BITS-2:0], sdin};
      selN_d     = selN;
      sclk_d     = sclk;
      armed_d    = armed_q;
      cnt_d      = cnt_q;
      shift_d    = shift_q;
      code_d     = code_q;
      mode_d     = mode_q;
      swr_d      = 1'b0;
      if (selFall) begin
         armed_d = 1'b1;
         cnt_d   = CNT_RESET;
         shift_d = '0;
      end else if (selRise || !armed_q) begin
         // Early rise drops the partial word; soft reset already ran at once
         armed_d = 1'b0;
         cnt_d   = CNT_RESET;
         shift_d = '0;
      end else if (clkFall) begin
         shift_d = word;
         if (cnt_q == CNT_LAST) begin
            // Frame complete: act at once, then wait for a new select fall
            armed_d = 1'b0;
            cnt_d   = CNT_RESET;
            if (word == SOFT_RESET_WORD) begin
               // Executed on the same edge, so a later rise cannot abort it
               swr_d  = 1'b1;
               code_d = presetCode;
               mode_d = MODE_NORMAL;
            end else begin
               code_d = word[CODE_BITS-1:0];
               mode_d = sdw_mode_t'({word[MODE_HI_POS], word[MODE_LO_POS]});
            end
         end else begin
            cnt_d = cnt_q + 5'h01;
         end
      end
      // Output stage control follows the stored mode
      conn_d = (mode_d == MODE_NORMAL);
      en_d   = (mode_d == MODE_NORMAL);
      p100_d = (mode_d == MODE_PULL_100K);
      p1k_d  = (mode_d == MODE_PULL_1K);
      seg_d  = thermoSeg(code_d);
      lad_d  = code_d[LADDER_BITS-1:0];
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Register everything; reset stands in for power-on
   always_ff @(posedge core_clk) begin
      if (srst) begin
         selN_q  <= 1'b1;
         sclk_q  <= 1'b1;
         armed_q <= 1'b0;
         cnt_q   <= CNT_RESET;
         shift_q <= '0;
         code_q  <= PRESET_MID ? CODE_MID : CODE_ZERO;
         mode_q  <= MODE_NORMAL;
         swr_q   <= 1'b0;
         conn_q  <= 1'b1;
         en_q    <= 1'b1;
         p100_q  <= 1'b0;
         p1k_q   <= 1'b0;
         seg_q   <= PRESET_MID ? 15'h00ff : 15'h0000;
         lad_q   <= '0;
      end else begin
         selN_q  <= selN_d;
         sclk_q  <= sclk_d;
         armed_q <= armed_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         code_q  <= code_d;
         mode_q  <= mode_d;
         swr_q   <= swr_d;
         conn_q  <= conn_d;
         en_q    <= en_d;
         p100_q  <= p100_d;
         p1k_q   <= p1k_d;
         seg_q   <= seg_d;
         lad_q   <= lad_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Every output is a register, so the switches never see a decode glitch
   assign dacCode         = code_q;
   assign opMode          = mode_q;
   assign outputConnected = conn_q;
   assign coreEnabled     = en_q;
   assign pull100k        = p100_q;
   assign pull1k          = p1k_q;
   assign segmentSwitches = seg_q;
   assign ladderSwitches  = lad_q;
   assign softResetPulse  = swr_q;
endmodule
`default_nettype wire

// ### core/sdw_host.sv
// Host end: Avalon-MM slave registers driving the three-wire writer
`default_nettype none
module sdw_host
   import sdw_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output var  logic [31:0] avs_readdata,
   output var  logic        avs_waitrequest,
   sdw_link_if.host         link
);
   typedef enum logic [2:0] {
      H_IDLE, H_PRE, H_LOW, H_HIGH, H_PARK
   } sdw_hstate_t;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   sdw_hstate_t st_q, st_d;
   logic [23:0] tx_q, tx_d;
   logic [4:0]  bit_q, bit_d;
   logic [7:0]  tim_q, tim_d;
   logic        park_q, park_d;
   logic        sel_q, sel_d;
   logic        clk_q, clk_d;
   logic        dat_q, dat_d;
   logic        done_q, done_d;
   logic [31:0] rd_q, rd_d;
   logic        wr_q, wr_d;

   // Bus and link sequencing
   always_comb begin
      st_d   = st_q;
      tx_d   = tx_q;
      bit_d  = bit_q;
      tim_d  = tim_q;
      park_d = park_q;
      sel_d  = sel_q;
      clk_d  = clk_q;
      dat_d  = dat_q;
      done_d = done_q;
      rd_d   = rd_q;
      wr_d   = 1'b1;
      // One wait cycle, then answer; words are refused only while busy
      if ((avs_read || avs_write) && avs_waitrequest) begin
         wr_d = 1'b0;
         if (avs_read) begin
            case (avs_address)
               REG_TXWORD: rd_d = {8'h00, tx_q};
               REG_CTRL:   rd_d = {31'h0, park_q};
               REG_STATUS: rd_d = {30'h0, done_q, (st_q != H_IDLE && st_q != H_PARK)};
               default:    rd_d = READ_UNMAPPED;
            endcase
         end else if (avs_address == REG_CTRL) begin
            park_d = avs_writedata[0];
         end else if (avs_address == REG_TXWORD &&
                      (st_q == H_IDLE || st_q == H_PARK)) begin
            tx_d   = avs_writedata[23:0];
            done_d = 1'b0;
            sel_d  = 1'b1;
            tim_d  = 8'(SEL_HIGH_CYC);
            st_d   = H_PRE;
         end
      end
      case (st_q)
         H_IDLE, H_PARK: ;
         H_PRE: begin
            // Select stays high long enough to give a clean falling edge
            if (tim_q > 8'h01) begin
               tim_d = tim_q - 8'h01;
            end else begin
               sel_d = 1'b0;
               dat_d = tx_q[23];
               bit_d = 5'h00;
               tim_d = 8'(HALF_DIV);
               st_d  = H_HIGH;
            end
         end
         H_HIGH: begin
            if (tim_q > 8'h01) begin
               tim_d = tim_q - 8'h01;
            end else begin
               clk_d = 1'b0;
               tim_d = 8'(HALF_DIV);
               st_d  = H_LOW;
            end
         end
         H_LOW: begin
            if (tim_q > 8'h01) begin
               tim_d = tim_q - 8'h01;
            end else begin
               clk_d = 1'b1;
               tim_d = 8'(HALF_DIV);
               if (bit_q == CNT_LAST) begin
                  done_d = 1'b1;
                  sel_d  = ~park_q;
                  st_d   = park_q ? H_PARK : H_IDLE;
               end else begin
                  bit_d = bit_q + 5'h01;
                  dat_d = tx_q[5'h16 - bit_q];
                  st_d  = H_HIGH;
               end
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q   <= H_IDLE;
         tx_q   <= '0;
         bit_q  <= 5'h00;
         tim_q  <= 8'h00;
         park_q <= 1'b0;
         sel_q  <= 1'b1;
         clk_q  <= 1'b1;
         dat_q  <= 1'b0;
         done_q <= 1'b0;
         rd_q   <= '0;
         wr_q   <= 1'b1;
      end else begin
         st_q   <= st_d;
         tx_q   <= tx_d;
         bit_q  <= bit_d;
         tim_q  <= tim_d;
         park_q <= park_d;
         sel_q  <= sel_d;
         clk_q  <= clk_d;
         dat_q  <= dat_d;
         done_q <= done_d;
         rd_q   <= rd_d;
         wr_q   <= wr_d;
      end
   end

   assign avs_readdata    = rd_q;
   assign avs_waitrequest = wr_q;
   assign link.frameSelN  = sel_q;
   assign link.shiftClk   = clk_q;
   assign link.serialData = dat_q;
endmodule
`default_nettype wire

// ### core/sdw_link_if.sv
// Three-wire link between host and converter write port
`default_nettype none
interface sdw_link_if;
   logic frameSelN;
   logic shiftClk;
   logic serialData;
   modport host   (output frameSelN, output shiftClk, output serialData);
   modport device (input frameSelN, input shiftClk, input serialData);
endinterface
`default_nettype wire

// ### core/sdw_pkg.sv
// Shared constants and types for the serial converter write port
`default_nettype none
package sdw_pkg;
   // ------------------------------------------------------------
   // Frame layout
   // ------------------------------------------------------------
   localparam int         FRAME_BITS    = 24;
   localparam int         CODE_BITS     = 16;
   localparam int         MODE_HI_POS   = 17;
   localparam int         MODE_LO_POS   = 16;
   localparam int         SEG_BITS      = 4;
   localparam int         SEG_COUNT     = 15;
   localparam int         LADDER_BITS   = 12;
   localparam logic [4:0] CNT_RESET     = 5'h00;
   localparam logic [4:0] CNT_LAST      = 5'h17;
   localparam logic [15:0] CODE_MID     = 16'h8000;
   localparam logic [15:0] CODE_ZERO    = 16'h0000;
   localparam logic [23:0] SOFT_RESET_WORD = 24'hffffff;

   // ------------------------------------------------------------
   // Timing (host side, core clock 10 MHz)
   // ------------------------------------------------------------
   localparam int         CORE_CLK_HZ   = 10_000_000;
   localparam int         SEL_HIGH_NS   = 33;
   localparam int         SEL_HIGH_CYC  =
      ((SEL_HIGH_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000) < 1 ? 1 :
      ((SEL_HIGH_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000);
   localparam int         LINK_MAX_HZ   = 30_000_000;
   localparam int         HALF_DIV      = 4; // Shift clock = core / (2*HALF_DIV)
   localparam int         WAKE_CYC      = 50; // Power-down exit, 5 us worst case

   // ------------------------------------------------------------
   // Host register map (Avalon word addresses)
   // ------------------------------------------------------------
   localparam logic [1:0] REG_TXWORD    = 2'h0;
   localparam logic [1:0] REG_CTRL      = 2'h1;
   localparam logic [1:0] REG_STATUS    = 2'h2;
   localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_TRISTATE,
      MODE_PULL_100K,
      MODE_PULL_1K
   } sdw_mode_t;
endpackage
`default_nettype wire

// ### core/sdw_sync2.sv
// Two-flop synchroniser for a bundle of levels
`default_nettype none
module sdw_sync2 #(
   parameter int WIDTH = 3
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async,
   output var  logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] synced_d;

   // First stage feeds only the second
   always_comb begin
      meta_d   = async;
      synced_d = meta_q;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         meta_q <= '1;
         synced <= '1;
      end else begin
         meta_q <= meta_d;
         synced <= synced_d;
      end
   end
endmodule
`default_nettype wire

// ### testbench/sdw_link_monitor.sv
// Concurrent checks on the link between host and converter ends
`default_nettype none
module sdw_link_monitor
   import sdw_pkg::*;
(
   input wire logic                   core_clk,
   input wire logic                   srst,
   input wire logic                   frameSelN,
   input wire logic                   shiftClk,
   input wire logic [CODE_BITS-1:0]   dacCode,
   input wire sdw_mode_t              opMode,
   input wire logic                   outputConnected,
   input wire logic                   pull1k,
   input wire logic [SEG_COUNT-1:0]   segmentSwitches,
   input wire logic [LADDER_BITS-1:0] ladderSwitches,
   input wire logic                   softResetPulse
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   // ---------------
   // Helper counter
   // ---------------
   logic        clkPrev_q;
   logic        selPrev_q;
   logic [4:0]  fallCnt_q;
   logic [4:0]  fallCnt_d;
   logic [15:0] thermo;

   // Raw falls since select fell; raw, so it leads the synced device view
   always_comb begin
      fallCnt_d = fallCnt_q;
      if (clkPrev_q && !shiftClk && !frameSelN && fallCnt_q != 5'h1f) begin
         fallCnt_d = fallCnt_q + 5'h01;
      end
      if (srst || (selPrev_q && !frameSelN)) begin
         fallCnt_d = 5'h00;
      end
      thermo = (16'h0001 << dacCode[15:12]) - 16'h0001;
   end

   // Registers only
   always_ff @(posedge core_clk) begin
      clkPrev_q <= shiftClk;
      selPrev_q <= frameSelN;
      fallCnt_q <= fallCnt_d;
   end

   // ---------------
   // Assertions
   // ---------------
   a_code_at_last: assert property ($changed(dacCode) |-> fallCnt_q == 5'h18)
      else $error("code moved off frame end");
   a_mode_at_last: assert property ($changed(opMode) |-> fallCnt_q == 5'h18)
      else $error("mode moved off frame end");
   a_ladder_direct: assert property ($stable(dacCode) [*3] |->
      ladderSwitches == dacCode[11:0]) else $error("ladder mismatch");
   a_segment_thermo: assert property ($stable(dacCode) [*3] |->
      segmentSwitches == thermo[14:0]) else $error("segment mismatch");
   a_mode_outputs: assert property ($stable(opMode) [*3] |->
      outputConnected == (opMode == MODE_NORMAL) && pull1k == (opMode == MODE_PULL_1K))
      else $error("mode outputs mismatch");
   a_soft_once: assert property (softResetPulse |=> !softResetPulse)
      else $error("soft reset pulse too long");
   a_soft_preset: assert property (softResetPulse |-> ##[0:3]
      (dacCode == CODE_MID && opMode == MODE_NORMAL)) else $error("no preset after reset");
   a_frame_len: assert property ($rose(frameSelN) |-> fallCnt_q == 5'h18)
      else $error("frame not 24 falls");
   a_clk_half: assert property ($fell(shiftClk) |-> !shiftClk [*4] ##1 shiftClk)
      else $error("shift clock half period off");
   a_idle_clk_high: assert property ($rose(frameSelN) |-> shiftClk)
      else $error("clock low at frame end");
endmodule
`default_nettype wire

// ### testbench/serial_dac_write_port_test.sv
// Bench joining host and converter ends, plus a hand-driven converter
`default_nettype none
module serial_dac_write_port_test
   import sdw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   core_clk;
   logic                   srst;
   logic [1:0]             avAddr;
   logic                   avRead;
   logic                   avWrite;
   logic [31:0]            avWdata;
   logic [31:0]            avRdata;
   logic                   avWait;
   logic [31:0]            rd;
   logic [CODE_BITS-1:0]   dacCode;
   logic [CODE_BITS-1:0]   dacCodeB;
   sdw_mode_t              opMode;
   sdw_mode_t              opModeB;
   logic                   outputConnected;
   logic                   coreEnabled;
   logic                   pull100k;
   logic                   pull1k;
   logic [SEG_COUNT-1:0]   segmentSwitches;
   logic [LADDER_BITS-1:0] ladderSwitches;
   logic                   softResetPulse;
   logic                   clkSeen;
   logic [23:0]            seenWord;
   int                     errTotal;
   int                     samplesChecked;
   int                     softPulses;
   logic [17:0]            frames [6] = '{18'h00000, 18'h10000, 18'h0ffff, 18'h2ffff,
                                          18'h3ffff, 18'h01234};
   sdw_link_if link ();
   sdw_link_if linkB ();

   // 10 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   sdw_host u_sdw_host (.core_clk, .srst, .avs_address(avAddr), .avs_read(avRead),
      .avs_write(avWrite), .avs_writedata(avWdata), .avs_readdata(avRdata),
      .avs_waitrequest(avWait), .link(link.host));
   sdw_device u_sdw_device (.core_clk, .srst, .link(link.device), .dacCode, .opMode,
      .outputConnected, .coreEnabled, .pull100k, .pull1k, .segmentSwitches,
      .ladderSwitches, .softResetPulse);
   sdw_device u_sdw_device_b (.core_clk, .srst, .link(linkB.device), .dacCode(dacCodeB),
      .opMode(opModeB), .outputConnected(), .coreEnabled(), .pull100k(), .pull1k(),
      .segmentSwitches(), .ladderSwitches(), .softResetPulse());
   sdw_link_monitor u_mon (.core_clk, .srst, .frameSelN(link.frameSelN),
      .shiftClk(link.shiftClk), .dacCode, .opMode, .outputConnected, .pull1k,
      .segmentSwitches, .ladderSwitches, .softResetPulse);

   // Wire capture at each clock fall; first bit ends up on top
   always @(posedge core_clk) begin
      clkSeen <= link.shiftClk;
      if (clkSeen && !link.shiftClk && !link.frameSelN) begin
         seenWord <= {seenWord[22:0], link.serialData};
      end
      if (softResetPulse === 1'b1) begin
         softPulses++;
      end
   end

   // ----------------
   // Tasks
   // ----------------
   task automatic summarize();
      $display("compares %0d mismatches %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until waitrequest is seen low; the bound cuts a hang
   task automatic busCycle(input logic [1:0] a, input logic wr, input logic [31:0] d,
                           output logic [31:0] q);
      int n;
      @(posedge core_clk);
      avAddr <= a;
      avWrite <= wr;
      avRead <= !wr;
      avWdata <= d;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (avWait !== 1'b0 && n < 50);
      q = avRdata;
      avRead <= 1'b0;
      avWrite <= 1'b0;
      check("waitrequest", 32'h0, {31'h0, avWait});
      if (avWait !== 1'b0) summarize(); // Timeout ends the run
   endtask

   task automatic regWr(input logic [1:0] a, input logic [31:0] d);
      logic [31:0] q;
      busCycle(a, 1'b1, d, q);
   endtask

   task automatic regRd(input logic [1:0] a, output logic [31:0] q);
      busCycle(a, 1'b0, 32'h0, q);
   endtask

   // Write a word, poll busy until clear, then allow the device latency
   task automatic sendWord(input logic [23:0] w);
      logic [31:0] q;
      int n;
      regWr(REG_TXWORD, {8'h00, w});
      n = 0;
      do begin
         regRd(REG_STATUS, q);
         n++;
      end while (q[0] !== 1'b0 && n < 200);
      check("busy", 32'h0, {31'h0, q[0]});
      if (q[0] !== 1'b0) summarize();
      repeat (4) @(posedge core_clk);
   endtask

   task automatic checkDev(input logic [15:0] c, input sdw_mode_t m);
      check("dacCode", c, dacCode);
      check("opMode", m, opMode);
      check("connected", m == MODE_NORMAL, outputConnected);
      check("core", m == MODE_NORMAL, coreEnabled);
      check("pull100k", m == MODE_PULL_100K, pull100k);
      check("ladder", c[11:0], ladderSwitches);
   endtask

   // Hand-driven frame, 800 ns clock; data inverts once released
   task automatic bang(input logic [23:0] w, input int bits);
      linkB.frameSelN <= 1'b0;
      for (int i = 23; i > 23 - bits; i--) begin
         linkB.serialData <= w[i];
         linkB.shiftClk <= 1'b1;
         repeat (4) @(posedge core_clk);
         linkB.shiftClk <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      linkB.shiftClk <= 1'b1;
      linkB.serialData <= ~linkB.serialData;
      linkB.frameSelN <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      srst = 1'b1;
      avAddr = 2'h0;
      avRead = 1'b0;
      avWrite = 1'b0;
      avWdata = 32'h0;
      linkB.frameSelN = 1'b1;
      linkB.shiftClk = 1'b1;
      linkB.serialData = 1'b0;
      repeat (4) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      checkDev(CODE_MID, MODE_NORMAL);
      check("segments", 32'h00ff, segmentSwitches);
      regRd(2'h3, rd);
      check("unmapped", READ_UNMAPPED, rd);
      for (int i = 0; i < 6; i++) begin
         sendWord({6'h00, frames[i]});
         check("wire", {6'h00, frames[i]}, seenWord);
         checkDev(frames[i][15:0], sdw_mode_t'(frames[i][17:16]));
         regRd(REG_STATUS, rd);
         check("status", 32'h2, rd);
         regRd(REG_TXWORD, rd);
         check("txword", {14'h0, frames[i]}, rd);
      end
      // Second word lands while busy and must be dropped
      regWr(REG_TXWORD, 32'h0000abcd);
      sendWord(24'h005555);
      checkDev(16'habcd, MODE_NORMAL);
      regWr(REG_CTRL, 32'h1);
      regRd(REG_CTRL, rd);
      check("park", 32'h1, {31'h0, rd[0]});
      sendWord(24'h020f0f);
      check("parkedSel", 32'h0, link.frameSelN);
      checkDev(16'h0f0f, MODE_PULL_100K);
      sendWord(24'h00f00f);
      repeat (WAKE_CYC) @(posedge core_clk);
      checkDev(16'hf00f, MODE_NORMAL);
      sendWord(SOFT_RESET_WORD);
      checkDev(CODE_MID, MODE_NORMAL);
      check("pulses", 32'h1, softPulses);
      // Clocks with select high must not count
      for (int i = 0; i < 6; i++) begin
         linkB.shiftClk <= 1'b0;
         repeat (4) @(posedge core_clk);
         linkB.shiftClk <= 1'b1;
         repeat (4) @(posedge core_clk);
      end
      bang(24'h01abcd, 10);
      check("abortCode", CODE_MID, dacCodeB);
      check("abortMode", MODE_NORMAL, opModeB);
      bang(24'h025a5a, 24);
      check("codeB", 32'h5a5a, dacCodeB);
      check("modeB", MODE_PULL_100K, opModeB);
      bang(SOFT_RESET_WORD, 24);
      check("resetB", CODE_MID, dacCodeB);
      summarize();
   end
endmodule
`default_nettype wire
